// ---- core/audsf_pkg.sv ----
// package for the audio serial fifo status block: offsets, fields, types
package audsf_pkg;

   // -------------------------------------------------------------------
   // fifo geometry
   // -------------------------------------------------------------------
   localparam int unsigned AUDSF_DEPTH    = 32;
   localparam logic [5:0]  AUDSF_FULL_CNT = 6'h20;
   localparam logic [5:0]  AUDSF_ZERO_CNT = 6'h00;

   // -------------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] AUDSF_OFS_CTRL     = 8'h00;
   localparam logic [7:0] AUDSF_OFS_INT_STAT = 8'h04;
   localparam logic [7:0] AUDSF_OFS_INT_MASK = 8'h08;
   localparam logic [7:0] AUDSF_OFS_FSTATE   = 8'h14;
   localparam logic [7:0] AUDSF_OFS_TX_PORT  = 8'h18;
   localparam logic [7:0] AUDSF_OFS_RX_PORT  = 8'h1C;
   localparam logic [7:0] AUDSF_OFS_THRESH   = 8'h24;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int unsigned AUDSF_FS_RXF   = 0;   // rx_threshold_flag
   localparam int unsigned AUDSF_FS_RXC   = 8;   // rx_fill_count lsb
   localparam int unsigned AUDSF_FS_TXF   = 16;  // tx_space_flag
   localparam int unsigned AUDSF_FS_TXC   = 24;  // tx_fill_count lsb
   localparam int unsigned AUDSF_TH_RX    = 0;   // rx_threshold_setting lsb
   localparam int unsigned AUDSF_TH_TX    = 8;   // tx_threshold_setting lsb
   localparam int unsigned AUDSF_CT_RXON  = 0;   // receive_on
   localparam int unsigned AUDSF_CT_TXON  = 1;   // transmit_on
   localparam int unsigned AUDSF_CT_PAD   = 2;   // padding configured
   localparam int unsigned AUDSF_CT_ALIGN = 3;   // data_alignment_select
   localparam int unsigned AUDSF_IRQ_W    = 5;   // events: rxth, txsp, rxov, txun, idle

   // -------------------------------------------------------------------
   // reset values and link word shape
   // -------------------------------------------------------------------
   localparam logic [3:0] AUDSF_CTRL_RST   = 4'h0;
   localparam logic [4:0] AUDSF_TH_RST     = 5'h00;
   localparam logic [4:0] AUDSF_MASK_RST   = 5'h00;
   localparam logic [4:0] AUDSF_DATA_LAST  = 5'h0F;  // 16 data bits per word
   localparam logic [4:0] AUDSF_PAD_LAST   = 5'h0F;  // 16 padding bits per slot

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {AUDSF_LNK_IDLE, AUDSF_LNK_DATA, AUDSF_LNK_PAD} audsf_lnk_st_t;

   typedef struct packed {
      logic        push;
      logic        pop;
      logic [31:0] wdata;
   } audsf_fifo_req_t;

   // mapped register offsets answer without error
   function automatic logic audsf_mapped(input logic [7:0] addr);
      return (addr == AUDSF_OFS_CTRL) || (addr == AUDSF_OFS_INT_STAT) ||
             (addr == AUDSF_OFS_INT_MASK) || (addr == AUDSF_OFS_FSTATE) ||
             (addr == AUDSF_OFS_TX_PORT) || (addr == AUDSF_OFS_RX_PORT) ||
             (addr == AUDSF_OFS_THRESH);
   endfunction

endpackage

// ---- core/audsf_sync.sv ----
// two-flop synchroniser for the link pins
`timescale 1ns/1ps
module audsf_sync
   import audsf_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_b,
   input  wire logic [1:0] i_async,
   output logic      [1:0] o_sync
);

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } audsf_sync_st_t;

   audsf_sync_st_t q;
   audsf_sync_st_t d;

   // -------------------------------------------------------------------
   // first stage feeds only the second
   // -------------------------------------------------------------------
   always_comb begin
      d    = q;
      d.s1 = i_async;
      d.s2 = q.s1;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_sync = q.s2;

endmodule

// ---- core/audsf_fifo.sv ----
// thirty-two word flip-flop fifo with fill count
`timescale 1ns/1ps
module audsf_fifo
   import audsf_pkg::*;
(
   input  wire logic      i_clk_sys,
   input  wire logic      i_rst_b,
   input  audsf_fifo_req_t i_req,
   output logic [31:0]    o_head,
   output logic [5:0]     o_count
);

   typedef struct packed {
      logic [AUDSF_DEPTH-1:0][31:0] mem;
      logic [4:0]                   wr_ptr;
      logic [4:0]                   rd_ptr;
      logic [5:0]                   count;
   } audsf_fifo_st_t;

   audsf_fifo_st_t q;
   audsf_fifo_st_t d;
   logic           push_ok;
   logic           pop_ok;

   // -------------------------------------------------------------------
   // push to tail, pop from head, count follows both
   // -------------------------------------------------------------------
   always_comb begin
      d       = q;
      push_ok = i_req.push && (q.count != AUDSF_FULL_CNT);
      pop_ok  = i_req.pop && (q.count != AUDSF_ZERO_CNT);
      if (push_ok) begin
         d.mem[q.wr_ptr] = i_req.wdata;
         d.wr_ptr        = q.wr_ptr + 5'h01;
      end
      if (pop_ok) begin
         d.rd_ptr = q.rd_ptr + 5'h01;
      end
      d.count = q.count + {5'h00, push_ok} - {5'h00, pop_ok};
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_head  = q.mem[q.rd_ptr];
   assign o_count = q.count;

endmodule

// ---- core/audsf_top.sv ----
// audio serial fifo status block: apb registers, fifos, link word sequencer
//
// Summary of operation
// - rx flag high when fill exceeds setting
// - rx flag sets automatically, software write clears
// - rx fill count readable in bits 13:8
// - tx flag high when free space exceeds setting
// - tx flag sets on bus clock, software clears
// - tx fill count readable in bits 29:24
// - unused status bits read zero, writes ignored
// - last data bit with padding enters padding
// - stop goes idle unless alignment with both off
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module audsf_top
   import audsf_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_b,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_irq,
   input  wire logic        i_lnk_sck,
   input  wire logic        i_lnk_rxd,
   output logic             o_lnk_txd,
   output logic             o_idle_status
);

   // -------------------------------------------------------------------
   // state of the block
   // -------------------------------------------------------------------
   typedef struct packed {
      logic                   rx_on;
      logic                   tx_on;
      logic                   pad_en;
      logic                   align_sel;
      logic [4:0]             rx_th;
      logic [4:0]             tx_th;
      logic                   rx_flag;
      logic                   tx_flag;
      logic [AUDSF_IRQ_W-1:0] int_stat;
      logic [AUDSF_IRQ_W-1:0] int_mask;
      logic                   irq;
      logic                   pready;
      logic [31:0]            prdata;
      logic                   pslverr;
      logic                   pop_ok;
      logic                   sck_prev;
      audsf_lnk_st_t          lnk_st;
      logic [4:0]             bit_cnt;
      logic [15:0]            tx_sh;
      logic [15:0]            rx_sh;
      logic                   txd;
      logic                   idle;
   } audsf_top_st_t;

   audsf_top_st_t          q;
   audsf_top_st_t          d;
   audsf_fifo_req_t        tx_req;
   audsf_fifo_req_t        rx_req;
   logic [31:0]            tx_head;
   logic [31:0]            rx_head;
   logic [5:0]             tx_cnt;
   logic [5:0]             rx_cnt;
   logic [5:0]             tx_free;
   logic [1:0]             lnk_sync;
   logic                   sck_s;
   logic                   rxd_s;
   logic                   sck_rise;
   logic                   sck_fall;
   logic                   setup;
   logic                   done;
   logic                   wr_done;
   logic                   rx_cond;
   logic                   tx_cond;
   logic                   stop_req;
   logic                   load_word;
   logic [AUDSF_IRQ_W-1:0] ev;
   logic [AUDSF_IRQ_W-1:0] w1c;

   // -------------------------------------------------------------------
   // sub-blocks
   // -------------------------------------------------------------------
   audsf_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_async   ({i_lnk_sck, i_lnk_rxd}),
      .o_sync    (lnk_sync)
   );

   audsf_fifo u_tx_fifo (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_req     (tx_req),
      .o_head    (tx_head),
      .o_count   (tx_cnt)
   );

   audsf_fifo u_rx_fifo (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_req     (rx_req),
      .o_head    (rx_head),
      .o_count   (rx_cnt)
   );

   // -------------------------------------------------------------------
   // link edges, bus phases and threshold conditions
   // -------------------------------------------------------------------
   assign sck_s    = lnk_sync[1];
   assign rxd_s    = lnk_sync[0];
   assign sck_rise = sck_s && !q.sck_prev;
   assign sck_fall = !sck_s && q.sck_prev;
   assign setup    = i_psel && !i_penable;
   assign done     = i_psel && i_penable && q.pready;
   assign wr_done  = done && i_pwrite;
   assign tx_free  = AUDSF_FULL_CNT - tx_cnt;
   assign rx_cond  = rx_cnt > {1'b0, q.rx_th};
   assign tx_cond  = tx_free > {1'b0, q.tx_th};
   assign stop_req = !q.tx_on && !q.rx_on;

   // -------------------------------------------------------------------
   // next-state logic
   // -------------------------------------------------------------------
   always_comb begin
      d            = q;
      tx_req       = '0;
      rx_req       = '0;
      ev           = '0;
      w1c          = '0;
      load_word    = 1'b0;
      d.sck_prev   = sck_s;

      // apb: no wait state, answer in the first access cycle
      d.pready  = setup;
      d.pslverr = setup && !audsf_mapped(i_paddr);
      d.prdata  = '0;
      d.pop_ok  = 1'b0;
      if (setup && !i_pwrite) begin
         unique case (i_paddr)
            AUDSF_OFS_CTRL: begin
               d.prdata[AUDSF_CT_RXON]  = q.rx_on;
               d.prdata[AUDSF_CT_TXON]  = q.tx_on;
               d.prdata[AUDSF_CT_PAD]   = q.pad_en;
               d.prdata[AUDSF_CT_ALIGN] = q.align_sel;
            end
            AUDSF_OFS_INT_STAT: d.prdata[AUDSF_IRQ_W-1:0] = q.int_stat;
            AUDSF_OFS_INT_MASK: d.prdata[AUDSF_IRQ_W-1:0] = q.int_mask;
            AUDSF_OFS_FSTATE: begin
               d.prdata[AUDSF_FS_RXF]                 = q.rx_flag;
               d.prdata[AUDSF_FS_RXC +: 6]            = rx_cnt;
               d.prdata[AUDSF_FS_TXF]                 = q.tx_flag;
               d.prdata[AUDSF_FS_TXC +: 6]            = tx_cnt;
            end
            AUDSF_OFS_RX_PORT: begin
               d.prdata = rx_head;
               d.pop_ok = rx_cnt != AUDSF_ZERO_CNT;
            end
            AUDSF_OFS_THRESH: begin
               d.prdata[AUDSF_TH_RX +: 5] = q.rx_th;
               d.prdata[AUDSF_TH_TX +: 5] = q.tx_th;
            end
            default: d.prdata = '0;
         endcase
      end else if (done) begin
         d.prdata = q.prdata;
      end

      // register writes take effect at the completing edge
      rx_req.pop = done && !i_pwrite && (i_paddr == AUDSF_OFS_RX_PORT) && q.pop_ok;
      if (wr_done) begin
         unique case (i_paddr)
            AUDSF_OFS_CTRL: begin
               d.rx_on     = i_pwdata[AUDSF_CT_RXON];
               d.tx_on     = i_pwdata[AUDSF_CT_TXON];
               d.pad_en    = i_pwdata[AUDSF_CT_PAD];
               d.align_sel = i_pwdata[AUDSF_CT_ALIGN];
            end
            AUDSF_OFS_INT_STAT: w1c = i_pwdata[AUDSF_IRQ_W-1:0];
            AUDSF_OFS_INT_MASK: d.int_mask = i_pwdata[AUDSF_IRQ_W-1:0];
            AUDSF_OFS_FSTATE: begin
               // writing zero clears a flag; reserved bits are ignored
               if (!i_pwdata[AUDSF_FS_RXF]) begin
                  d.rx_flag = 1'b0;
               end
               if (!i_pwdata[AUDSF_FS_TXF]) begin
                  d.tx_flag = 1'b0;
               end
            end
            AUDSF_OFS_TX_PORT: begin
               tx_req.push  = 1'b1;
               tx_req.wdata = i_pwdata;
            end
            AUDSF_OFS_THRESH: begin
               d.rx_th = i_pwdata[AUDSF_TH_RX +: 5];
               d.tx_th = i_pwdata[AUDSF_TH_TX +: 5];
            end
            default: d.rx_on = q.rx_on;
         endcase
      end

      // flags: automatic set wins over a software clear
      if (rx_cond) begin
         d.rx_flag = 1'b1;
      end
      if (tx_cond) begin
         d.tx_flag = 1'b1;
      end
      ev[0] = rx_cond && !q.rx_flag;
      ev[1] = tx_cond && !q.tx_flag;

      // link word sequencer
      unique case (q.lnk_st)
         AUDSF_LNK_IDLE: begin
            if (sck_fall && !stop_req) begin
               load_word = 1'b1;
            end
         end
         AUDSF_LNK_DATA: begin
            if (sck_rise) begin
               d.rx_sh = {q.rx_sh[14:0], rxd_s};
               if (q.bit_cnt == AUDSF_DATA_LAST && q.rx_on) begin
                  // shift register to fifo transfer at the last bit
                  rx_req.push  = 1'b1;
                  rx_req.wdata = {16'h0000, q.rx_sh[14:0], rxd_s};
                  ev[2]        = rx_cnt == AUDSF_FULL_CNT;
               end
            end
            if (sck_fall) begin
               if (q.bit_cnt == AUDSF_DATA_LAST) begin
                  d.bit_cnt = 5'h00;
                  if (stop_req) begin
                     // stop: straight to idle unless alignment keeps the slot
                     d.lnk_st = q.align_sel ? AUDSF_LNK_PAD : AUDSF_LNK_IDLE;
                     d.txd    = 1'b0;
                  end else if (q.pad_en) begin
                     d.lnk_st = AUDSF_LNK_PAD;
                     d.txd    = 1'b0;
                  end else begin
                     load_word = 1'b1;
                  end
               end else begin
                  d.bit_cnt = q.bit_cnt + 5'h01;
                  d.tx_sh   = {q.tx_sh[14:0], 1'b0};
                  d.txd     = q.tx_sh[14];
               end
            end
         end
         AUDSF_LNK_PAD: begin
            if (sck_fall) begin
               if (q.bit_cnt == AUDSF_PAD_LAST) begin
                  d.bit_cnt = 5'h00;
                  if (stop_req) begin
                     d.lnk_st = AUDSF_LNK_IDLE;
                  end else begin
                     load_word = 1'b1;
                  end
               end else begin
                  d.bit_cnt = q.bit_cnt + 5'h01;
               end
            end
         end
      endcase

      // start of a data word: take the next transmit word or zeros
      if (load_word) begin
         d.lnk_st  = AUDSF_LNK_DATA;
         d.bit_cnt = 5'h00;
         d.tx_sh   = (q.tx_on && tx_cnt != AUDSF_ZERO_CNT) ? tx_head[15:0] : 16'h0000;
         d.txd     = d.tx_sh[15];
         tx_req.pop = q.tx_on;
         ev[3]      = q.tx_on && (tx_cnt == AUDSF_ZERO_CNT);
      end
      ev[4]  = (d.lnk_st == AUDSF_LNK_IDLE) && (q.lnk_st != AUDSF_LNK_IDLE);
      d.idle = d.lnk_st == AUDSF_LNK_IDLE;

      // interrupts: sticky, write-one clears, set wins
      d.int_stat = (q.int_stat & ~w1c) | ev;
      d.irq      = |(q.int_stat & q.int_mask);
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q           <= '0;
         q.rx_on     <= AUDSF_CTRL_RST[AUDSF_CT_RXON];
         q.tx_on     <= AUDSF_CTRL_RST[AUDSF_CT_TXON];
         q.pad_en    <= AUDSF_CTRL_RST[AUDSF_CT_PAD];
         q.align_sel <= AUDSF_CTRL_RST[AUDSF_CT_ALIGN];
         q.rx_th     <= AUDSF_TH_RST;
         q.tx_th     <= AUDSF_TH_RST;
         q.int_mask  <= AUDSF_MASK_RST;
         q.lnk_st    <= AUDSF_LNK_IDLE;
         q.idle      <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_prdata      = q.prdata;
   assign o_pready      = q.pready;
   assign o_pslverr     = q.pslverr;
   assign o_irq         = q.irq;
   assign o_lnk_txd     = q.txd;
   assign o_idle_status = q.idle;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   a_rx_flag_set: assert property (rx_cond |=> q.rx_flag)
      else $error("rx flag not set above threshold");
   a_rx_flag_clr: assert property (wr_done && i_paddr == AUDSF_OFS_FSTATE && !i_pwdata[0] && !rx_cond
      |=> !q.rx_flag)
      else $error("rx flag not cleared by write");
   a_rx_cnt_read: assert property (setup && !i_pwrite && i_paddr == AUDSF_OFS_FSTATE
      |=> o_pready && o_prdata[13:8] == $past(rx_cnt))
      else $error("rx fill count misread");
   a_tx_flag_set: assert property (tx_cond && !q.tx_flag |=> q.tx_flag && q.int_stat[1])
      else $error("tx flag not set on free space");
   a_tx_flag_hold: assert property (q.tx_flag && !(wr_done && i_paddr == AUDSF_OFS_FSTATE) |=> q.tx_flag)
      else $error("tx flag dropped without a write");
   a_tx_cnt_read: assert property (setup && !i_pwrite && i_paddr == AUDSF_OFS_FSTATE
      |=> o_prdata[29:24] == $past(tx_cnt))
      else $error("tx fill count misread");
   a_fs_reserved: assert property (setup && !i_pwrite && i_paddr == AUDSF_OFS_FSTATE
      |=> o_prdata[7:1] == 7'h00 && o_prdata[15:14] == 2'h0 && o_prdata[23:17] == 7'h00
          && o_prdata[31:30] == 2'h0)
      else $error("reserved status bits not zero");
   a_data_to_pad: assert property (q.lnk_st == AUDSF_LNK_DATA && sck_fall && q.bit_cnt == AUDSF_DATA_LAST
      && q.pad_en && !stop_req |=> q.lnk_st == AUDSF_LNK_PAD && !o_idle_status)
      else $error("no padding after data word");
   a_stop_idle: assert property (q.lnk_st == AUDSF_LNK_DATA && sck_fall && q.bit_cnt == AUDSF_DATA_LAST
      && stop_req && !q.align_sel |=> q.lnk_st == AUDSF_LNK_IDLE ##1 o_idle_status)
      else $error("stop did not reach idle");
   a_rx_cnt_step: assert property (rx_req.push && !rx_req.pop && rx_cnt != AUDSF_FULL_CNT
      |=> rx_cnt == $past(rx_cnt) + 6'h01)
      else $error("rx count missed a push");
   a_cnt_bound: assert property (rx_cnt <= AUDSF_FULL_CNT && tx_cnt <= AUDSF_FULL_CNT)
      else $error("fifo count above depth");

   c_pad_entered: cover property (q.lnk_st == AUDSF_LNK_DATA ##1 q.lnk_st == AUDSF_LNK_PAD);
   c_rx_flag_rise: cover property (!q.rx_flag ##1 q.rx_flag);
   c_tx_underrun: cover property (q.int_stat[3]);
   c_irq_high: cover property (o_irq);

endmodule

// ---- sim/audsf_codec.sv ----
// codec model: link bit clock within frames, receive pattern, transmit capture
`timescale 1ns/1ps
module audsf_codec (
   input  wire logic        i_run,
   input  wire logic        i_txd,
   output logic             o_sck,
   output logic             o_rxd,
   output logic [47:0]      o_cap,
   output logic [6:0]       o_bits
);
   // -------------------------------------------------------------------
   // link model
   // -------------------------------------------------------------------
   localparam logic [15:0] PAT = 16'hA5C3;
   logic [3:0]  fall_q;

   // 400 ns bit clock, odd phase offset; idle high and data toggling outside frames
   // one process owns every model signal, so no start-up edge is captured by accident
   initial begin
      o_sck  = 1'b1;
      o_rxd  = 1'b0;
      o_cap  = 48'h0;
      o_bits = 7'h00;
      fall_q = 4'h0;
      #7;
      forever begin
         #200;
         if (!i_run) begin
            o_sck = 1'b1;
            o_rxd = ~o_rxd;
         end else if (o_sck) begin
            // falling edge: msb first, one data bit per fall
            o_sck  = 1'b0;
            o_rxd  = PAT[4'hF - fall_q];
            fall_q = fall_q + 4'h1;
         end else begin
            // rising edge: capture the first three slots sent by the block
            o_sck = 1'b1;
            if (o_bits < 7'd48) begin
               o_cap  = {o_cap[46:0], i_txd};
               o_bits = o_bits + 7'd1;
            end
         end
      end
   end
endmodule

// ---- sim/audsf_top_tb_top.sv ----
// self-checking testbench for the audio serial fifo status block
`timescale 1ns/1ps
module audsf_top_tb_top
   import audsf_pkg::*;
   ;
   // -------------------------------------------------------------------
   // bench
   // -------------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst_b   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, irq, sck, rxd, txd, idle, e, run = 1'b0;
   logic [47:0] cap;
   logic [6:0]  bits;
   int          error_cnt = 0, total_checks = 0, cyc = 0, i, k;
   // rows: {slverr, addr, expected read}
   logic [40:0] rows [6] = '{{1'b0, AUDSF_OFS_CTRL, 32'h0}, {1'b0, AUDSF_OFS_THRESH, 32'h0},
      {1'b0, AUDSF_OFS_INT_MASK, 32'h0}, {1'b0, AUDSF_OFS_FSTATE, 32'h0001_0000},
      {1'b1, 8'h30, 32'h0}, {1'b0, AUDSF_OFS_RX_PORT, 32'h0}};

   audsf_top u_audsf_top (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_irq(irq), .i_lnk_sck(sck), .i_lnk_rxd(rxd), .o_lnk_txd(txd),
      .o_idle_status(idle));
   audsf_codec u_audsf_codec (.i_run(run), .i_txd(txd), .o_sck(sck), .o_rxd(rxd), .o_cap(cap), .o_bits(bits));

   // 20 MHz clock and hang limit
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         finish_test();
      end
   end

   // one apb transfer: setup, access held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rv,
            output logic ev);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rv      = prdata;
      ev      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, r, e);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      chk({31'h0, idle}, 32'h1);
      for (i = 0; i < 6; i++) begin
         rd(rows[i][39:32]);
         chk(r, rows[i][31:0]);
         chk({31'h0, e}, {31'h0, rows[i][40]});
      end
      // tx space flag sticky, then cleared by a zero write
      wr(AUDSF_OFS_THRESH, 32'h0000_1F00);
      for (i = 0; i < 3; i++) wr(AUDSF_OFS_TX_PORT, 32'h1000 + i);
      rd(AUDSF_OFS_FSTATE);
      chk(r, 32'h0301_0000);
      wr(AUDSF_OFS_FSTATE, 32'h0);
      rd(AUDSF_OFS_FSTATE);
      chk(r, 32'h0300_0000);
      // fill to full, one extra write refused
      for (i = 3; i < 33; i++) wr(AUDSF_OFS_TX_PORT, 32'h1000 + i);
      rd(AUDSF_OFS_FSTATE);
      chk(r, 32'h2000_0000);
      // link run with padding, then stop and idle interrupt
      wr(AUDSF_OFS_INT_STAT, 32'h1F);
      wr(AUDSF_OFS_INT_MASK, 32'h10);
      wr(AUDSF_OFS_CTRL, 32'h7);
      run <= 1'b1;
      for (k = 0; k < 4000 && bits < 7'd48; k++) @(posedge clk_sys);
      wr(AUDSF_OFS_CTRL, 32'h0);
      for (k = 0; k < 2000 && idle !== 1'b1; k++) @(posedge clk_sys);
      run <= 1'b0;
      chk({31'h0, idle}, 32'h1);
      chk(cap[31:0], {16'h0, 16'h1001});
      chk({16'h0, cap[47:32]}, 32'h1000);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      rd(AUDSF_OFS_FSTATE);
      chk(r & 32'h1, 32'h1);
      rd(AUDSF_OFS_RX_PORT);
      chk(r, 32'h0000_A5C3);
      wr(AUDSF_OFS_INT_STAT, 32'h1F);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      // alignment with both directions off: the stop passes through a padding slot
      wr(AUDSF_OFS_CTRL, 32'hB);
      run <= 1'b1;
      repeat (40) @(posedge sck);
      wr(AUDSF_OFS_CTRL, 32'h8);
      for (k = 0; k < 40 && idle !== 1'b1; k++) @(negedge sck);
      run <= 1'b0;
      chk({31'h0, idle}, 32'h1);
      chk((k > 17) ? 32'h1 : 32'h0, 32'h1);
      finish_test();
   end
endmodule
